// ### bma_defs.svh
// Constants for the bit-reversed and modulo effective-address generator
`ifndef BMA_DEFS_SVH
`define BMA_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define BMA_ADDR_W      16
`define BMA_MOD_W       15
`define BMA_SEL_W       4
`define BMA_MODE_W      3

// ****************************************************************
// Field codes and steps
// ****************************************************************
`define BMA_STACK_SEL   4'hF
`define BMA_WORD_STEP   16'h0002
`define BMA_BYTE_STEP   16'h0001
`define BMA_ONE         16'h0001

// ****************************************************************
// Reset values
// ****************************************************************
`define BMA_ADDR_RST    16'h0000
`define BMA_MOD_RST     15'h0000
`define BMA_SEL_RST     4'h0

`endif

// ### bma_pkg.sv
// Types shared by the address generator modules
`default_nettype none

package bma_pkg;

  // Addressing modes that the instruction decode presents
  typedef enum logic [2:0] {
    bma_mode_indirect,
    bma_mode_post_inc,
    bma_mode_post_dec,
    bma_mode_pre_inc,
    bma_mode_pre_dec,
    bma_mode_reg_offset
  } bma_mode_e;

  // Access size
  typedef enum logic {
    bma_size_word,
    bma_size_byte
  } bma_size_e;

endpackage

`default_nettype wire

// ### bma_wrap_if.sv
// Carrier between the address generator and its modulo wrap unit
`timescale 1ns/1ns
`default_nettype none

interface bma_wrap_if #(
  parameter int ADDR_W = 16
);
  logic              enable;
  logic              incrementing;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] start;
  logic [ADDR_W-1:0] finish;
  logic [ADDR_W-1:0] result;
  logic              wrapped;

  modport requester (output enable, incrementing, addr, start, finish,
                     input  result, wrapped);
  modport wrapper   (input  enable, incrementing, addr, start, finish,
                     output result, wrapped);
endinterface

`default_nettype wire

// ### bma_modulo_wrap.sv
// Modulo boundary check and wrap for one candidate address
`timescale 1ns/1ns
`default_nettype none
`include "bma_defs.svh"

module bma_modulo_wrap #(
  parameter int ADDR_W = 16
) (
  bma_wrap_if.wrapper wrap
);

  logic [ADDR_W-1:0] length;
  logic              over_top;
  logic              under_bottom;

  // Buffer length spans both boundaries inclusively
  always_comb
  begin
    length       = ADDR_W'(wrap.finish - wrap.start + ADDR_W'(`BMA_ONE));
    over_top     = wrap.addr > wrap.finish;   // Beyond, not only equal
    under_bottom = wrap.addr < wrap.start;
  end

  // Direction picks which boundary counts; the other is ignored
  always_comb
  begin
    wrap.result  = wrap.addr;
    wrap.wrapped = 1'b0;
    if (wrap.enable)
    begin
      if (wrap.incrementing && over_top)
      begin
        wrap.result  = ADDR_W'(wrap.addr - length);
        wrap.wrapped = 1'b1;
      end
      else if (!wrap.incrementing && under_bottom)
      begin
        wrap.result  = ADDR_W'(wrap.addr + length);
        wrap.wrapped = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### bma_address_gen.sv
// X-side effective-address generator with modulo and bit-reversed modes
`timescale 1ns/1ns
`default_nettype none
`include "bma_defs.svh"

module bma_address_gen #(
  parameter int ADDR_W = `BMA_ADDR_W,
  parameter int MOD_W  = `BMA_MOD_W,
  parameter int SEL_W  = `BMA_SEL_W
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // Request from the instruction decode
  input  wire logic              req_valid_in,
  input  wire logic [SEL_W-1:0]  ptr_index_in,
  input  wire logic [ADDR_W-1:0] ptr_value_in,
  input  wire logic [ADDR_W-1:0] offset_value_in,
  input  wire logic [2:0]        mode_in,
  input  wire logic              size_byte_in,
  input  wire logic              write_in,
  // Modulo configuration
  input  wire logic              modulo_enable_in,
  input  wire logic [SEL_W-1:0]  modulo_pointer_select_in,
  input  wire logic [ADDR_W-1:0] modulo_start_in,
  input  wire logic [ADDR_W-1:0] modulo_end_in,
  // Bit-reversal configuration
  input  wire logic [SEL_W-1:0]  base_pointer_select_in,
  input  wire logic              bitrev_enable_in,
  input  wire logic [MOD_W-1:0]  bitrev_modifier_value_in,
  // Results, one cycle after the request
  output logic                   ea_valid_out,
  output logic [ADDR_W-1:0]      ea_out,
  output logic                   wb_en_out,
  output logic [SEL_W-1:0]       wb_index_out,
  output logic [ADDR_W-1:0]      wb_value_out,
  output logic                   bitrev_active_out,
  output logic                   modulo_wrapped_out,
  output logic                   modifier_hazard_out
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Mirror a word end to end
  function automatic logic [ADDR_W-1:0] bit_rev(input logic [ADDR_W-1:0] value);
    logic [ADDR_W-1:0] mirrored;
    mirrored = '0;
    for (int i = 0; i < ADDR_W; i++)
    begin
      mirrored[i] = value[ADDR_W-1-i];
    end
    return mirrored;
  endfunction

  // Carry runs from the top bit down; built from an ordinary adder
  // between two mirrors so synthesis reuses its fast carry chain
  function automatic logic [ADDR_W-1:0] rev_carry_add(input logic [ADDR_W-1:0] a,
                                                      input logic [ADDR_W-1:0] b);
    return bit_rev(ADDR_W'(bit_rev(a) + bit_rev(b)));
  endfunction

  // True for the two increment forms of register indirect
  function automatic logic is_inc_mode(input bma_pkg::bma_mode_e mode);
    return (mode == bma_pkg::bma_mode_pre_inc) || (mode == bma_pkg::bma_mode_post_inc);
  endfunction

  // True for any mode that changes the pointer register
  function automatic logic is_modify_mode(input bma_pkg::bma_mode_e mode);
    return (mode == bma_pkg::bma_mode_pre_inc)  || (mode == bma_pkg::bma_mode_post_inc) ||
           (mode == bma_pkg::bma_mode_pre_dec)  || (mode == bma_pkg::bma_mode_post_dec);
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************

  bma_pkg::bma_mode_e mode;
  bma_pkg::bma_size_e size;
  logic [ADDR_W-1:0]  step;
  logic               modulo_hit;
  logic               bitrev_hit;
  logic [ADDR_W-1:0]  scaled_modifier;
  logic [ADDR_W-1:0]  word_ptr;

  // Decode mode, size and which special mode owns this pointer
  always_comb
  begin
    mode = bma_pkg::bma_mode_e'(mode_in);
    size = size_byte_in ? bma_pkg::bma_size_byte : bma_pkg::bma_size_word;
    step = (size == bma_pkg::bma_size_byte) ? ADDR_W'(`BMA_BYTE_STEP)
                                            : ADDR_W'(`BMA_WORD_STEP);
    // Any working register may be the modulo pointer
    modulo_hit = modulo_enable_in && (ptr_index_in == modulo_pointer_select_in);
    // Writes only, words only, increment forms only, never the stack
    bitrev_hit = bitrev_enable_in && write_in &&
                 (size == bma_pkg::bma_size_word) && is_inc_mode(mode) &&
                 (base_pointer_select_in != SEL_W'(`BMA_STACK_SEL)) &&
                 (ptr_index_in == base_pointer_select_in);
    // Modifier counts in words, so shift it into a byte offset
    scaled_modifier = ADDR_W'({bitrev_modifier_value_in, 1'b0});
    word_ptr        = ptr_value_in & ~ADDR_W'(`BMA_ONE);
  end

  // ****************************************************************
  // Normal address arithmetic
  // ****************************************************************

  logic [ADDR_W-1:0] raw_ea;
  logic [ADDR_W-1:0] raw_next;
  logic              raw_incrementing;

  // Address that the mode forms before any boundary correction
  always_comb
  begin
    raw_ea           = ptr_value_in;
    raw_next         = ptr_value_in;
    raw_incrementing = 1'b1;
    case (mode)
      bma_pkg::bma_mode_post_inc:
      begin
        raw_next = ADDR_W'(ptr_value_in + step);
      end
      bma_pkg::bma_mode_post_dec:
      begin
        raw_next         = ADDR_W'(ptr_value_in - step);
        raw_incrementing = 1'b0;
      end
      bma_pkg::bma_mode_pre_inc:
      begin
        raw_next = ADDR_W'(ptr_value_in + step);
        raw_ea   = raw_next;
      end
      bma_pkg::bma_mode_pre_dec:
      begin
        raw_next         = ADDR_W'(ptr_value_in - step);
        raw_ea           = raw_next;
        raw_incrementing = 1'b0;
      end
      bma_pkg::bma_mode_reg_offset:
      begin
        // A negative offset walks the buffer downward
        raw_ea           = ADDR_W'(ptr_value_in + offset_value_in);
        raw_incrementing = !offset_value_in[ADDR_W-1];
      end
      default:
      begin
        raw_ea = ptr_value_in;
      end
    endcase
  end

  // ****************************************************************
  // Modulo correction
  // ****************************************************************

  bma_wrap_if #(.ADDR_W(ADDR_W)) wrap ();

  // Offset mode corrects the address itself; modify modes correct
  // the new pointer, which for pre-modify is also the address
  always_comb
  begin
    wrap.enable       = modulo_hit && (is_modify_mode(mode) ||
                                       (mode == bma_pkg::bma_mode_reg_offset));
    wrap.incrementing = raw_incrementing;
    wrap.addr         = (mode == bma_pkg::bma_mode_reg_offset) ? raw_ea : raw_next;
    wrap.start        = modulo_start_in;
    wrap.finish       = modulo_end_in;
  end

  bma_modulo_wrap #(
    .ADDR_W (ADDR_W)
  ) u_modulo_wrap (
    .wrap   (wrap)
  );

  // ****************************************************************
  // Final selection
  // ****************************************************************

  logic [ADDR_W-1:0] next_ea;
  logic [ADDR_W-1:0] next_wb_value;
  logic              next_wb_en;
  logic              next_wrapped;
  logic [ADDR_W-1:0] bitrev_next;

  // Bit reversal first, then modulo, then plain arithmetic
  always_comb
  begin
    // Pointer plus modifier; the mode's own step plays no part
    bitrev_next   = rev_carry_add(word_ptr, scaled_modifier) & ~ADDR_W'(`BMA_ONE);
    next_ea       = raw_ea;
    next_wb_value = raw_next;
    next_wb_en    = is_modify_mode(mode);
    next_wrapped  = 1'b0;
    if (bitrev_hit)
    begin
      // Takes precedence over a modulo setting on the same pointer
      next_ea       = (mode == bma_pkg::bma_mode_pre_inc) ? bitrev_next : word_ptr;
      next_wb_value = bitrev_next;
      next_wb_en    = 1'b1;
    end
    else if (mode == bma_pkg::bma_mode_reg_offset)
    begin
      next_ea      = wrap.result;
      next_wb_en   = 1'b0;                  // Pointer left as it was
      next_wrapped = wrap.wrapped;
    end
    else if (is_modify_mode(mode))
    begin
      // Corrected value goes back to the register
      next_wb_value = wrap.result;
      next_wrapped  = wrap.wrapped;
      if ((mode == bma_pkg::bma_mode_pre_inc) || (mode == bma_pkg::bma_mode_pre_dec))
      begin
        next_ea = wrap.result;
      end
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************

  // Effective address and its valid flag
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ea_valid_out <= 1'b0;
      ea_out       <= ADDR_W'(`BMA_ADDR_RST);
    end
    else
    begin
      ea_valid_out <= req_valid_in;
      if (req_valid_in)
      begin
        ea_out <= next_ea;
      end
    end
  end

  // Pointer write-back, only from modify modes or bit reversal
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wb_en_out    <= 1'b0;
      wb_index_out <= SEL_W'(`BMA_SEL_RST);
      wb_value_out <= ADDR_W'(`BMA_ADDR_RST);
    end
    else
    begin
      wb_en_out <= req_valid_in && next_wb_en;
      if (req_valid_in)
      begin
        wb_index_out <= ptr_index_in;
        wb_value_out <= next_wb_value;
      end
    end
  end

  // Status of the last request, for the core's trace logic
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bitrev_active_out  <= 1'b0;
      modulo_wrapped_out <= 1'b0;
    end
    else
    begin
      bitrev_active_out  <= req_valid_in && bitrev_hit;
      modulo_wrapped_out <= req_valid_in && next_wrapped;
    end
  end

  // ****************************************************************
  // Modifier update hazard
  // ****************************************************************

  logic [MOD_W-1:0] last_modifier;
  logic             modifier_changed;

  // Track modifier changes; one cycle is the window of the hazard
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      last_modifier    <= MOD_W'(`BMA_MOD_RST);
      modifier_changed <= 1'b0;
    end
    else
    begin
      last_modifier    <= bitrev_modifier_value_in;
      modifier_changed <= bitrev_modifier_value_in != last_modifier;
    end
  end

  // Flags an indirect read through the reversal pointer right after a
  // modifier change; the address is still formed, only reported
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      modifier_hazard_out <= 1'b0;
    end
    else
    begin
      modifier_hazard_out <= req_valid_in && !write_in && bitrev_enable_in &&
                             modifier_changed &&
                             (mode != bma_pkg::bma_mode_reg_offset) &&
                             (ptr_index_in == base_pointer_select_in);
    end
  end

endmodule

`default_nettype wire

// ### bma_core_model.sv
// Core register file model that feeds pointers and applies write-backs
`timescale 1ns/1ns
`default_nettype none

module bma_core_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        load_in,
  input  wire logic [3:0]  index_in,
  input  wire logic [15:0] load_value_in,
  input  wire logic        wb_en_in,
  input  wire logic [3:0]  wb_index_in,
  input  wire logic [15:0] wb_value_in,
  output logic      [15:0] ptr_value_out
);
  // ****************************************************************
  // Working registers
  // ****************************************************************
  logic [15:0] regs [16];

  // Write-back lands first, a preload after it wins on the same index
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 16; i++)
        regs[i] <= 16'h0000;
    end
    else
    begin
      if (wb_en_in)
        regs[wb_index_in] <= wb_value_in;
      if (load_in)
        regs[index_in] <= load_value_in;
    end
  end

  // Pointer is presented together with the request, no forwarding
  assign ptr_value_out = regs[index_in];
endmodule

`default_nettype wire

// ### bma_address_gen_sva.sv
// Port checks for the address generator
`timescale 1ns/1ns
`default_nettype none

module bma_address_gen_sva #(
  parameter int ADDR_W = 16,
  parameter int SEL_W  = 4
) (
  input wire logic              clock_in,
  input wire logic              rst_in,
  input wire logic              req_valid_in,
  input wire logic [SEL_W-1:0]  ptr_index_in,
  input wire logic [2:0]        mode_in,
  input wire logic              size_byte_in,
  input wire logic              write_in,
  input wire logic              modulo_enable_in,
  input wire logic [SEL_W-1:0]  modulo_pointer_select_in,
  input wire logic [SEL_W-1:0]  base_pointer_select_in,
  input wire logic              bitrev_enable_in,
  input wire logic [ADDR_W-1:0] ea_out,
  input wire logic              wb_en_out,
  input wire logic [SEL_W-1:0]  wb_index_out,
  input wire logic [ADDR_W-1:0] wb_value_out,
  input wire logic              bitrev_active_out,
  input wire logic              modulo_wrapped_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Post-increment or pre-increment indirect
  logic inc_mode;
  assign inc_mode = (mode_in == 3'h1) || (mode_in == 3'h3);

  property p_brev_on; req_valid_in && bitrev_enable_in && write_in && !size_byte_in && inc_mode
    && base_pointer_select_in != 4'hF && ptr_index_in == base_pointer_select_in
    |=> bitrev_active_out; endproperty
  a_brev_on: assert property (p_brev_on) else $error("reversal not used");
  property p_brev_off; req_valid_in && (size_byte_in || !inc_mode || !bitrev_enable_in
    || base_pointer_select_in == 4'hF) |=> !bitrev_active_out; endproperty
  a_brev_off: assert property (p_brev_off) else $error("reversal used wrongly");
  property p_brev_read; req_valid_in && !write_in |=> !bitrev_active_out; endproperty
  a_brev_read: assert property (p_brev_read) else $error("reversal on a read");
  property p_lsb; bitrev_active_out |-> !ea_out[0] && !wb_value_out[0]; endproperty
  a_lsb: assert property (p_lsb) else $error("odd reversed address");
  property p_pre_eq; bitrev_active_out && $past(mode_in) == 3'h3 |-> ea_out == wb_value_out;
  endproperty
  a_pre_eq: assert property (p_pre_eq) else $error("pre-increment sum differs");
  property p_offset; req_valid_in && mode_in == 3'h5 |=> !wb_en_out; endproperty
  a_offset: assert property (p_offset) else $error("offset mode wrote back");
  property p_wb_mod; req_valid_in && mode_in inside {3'h1, 3'h2, 3'h3, 3'h4}
    |=> wb_en_out && wb_index_out == $past(ptr_index_in); endproperty
  a_wb_mod: assert property (p_wb_mod) else $error("missing write-back");
  property p_wrap_sel; modulo_wrapped_out |-> $past(modulo_enable_in)
    && $past(ptr_index_in) == $past(modulo_pointer_select_in); endproperty
  a_wrap_sel: assert property (p_wrap_sel) else $error("wrap on other pointer");
  property p_prec; bitrev_active_out |-> !modulo_wrapped_out; endproperty
  a_prec: assert property (p_prec) else $error("modulo beat reversal");
endmodule

bind bma_address_gen bma_address_gen_sva #(.ADDR_W(ADDR_W), .SEL_W(SEL_W)) u_sva (
  .clock_in, .rst_in, .req_valid_in, .ptr_index_in, .mode_in, .size_byte_in,
  .write_in, .modulo_enable_in, .modulo_pointer_select_in, .base_pointer_select_in,
  .bitrev_enable_in, .ea_out, .wb_en_out, .wb_index_out, .wb_value_out,
  .bitrev_active_out, .modulo_wrapped_out);

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the address generator
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ****************************************************************
  // Stimulus, expectations and instances
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  idx;
    logic [15:0] ptr;
    logic [15:0] off;
    logic [2:0]  mode;
    logic        byt;
    logic        wr;
    logic [15:0] ea;
    logic        wben;
    logic [15:0] wbv;
    logic        br;
    logic        wrp;
  } bma_row_s;
  localparam logic [2:0] m_in = bma_pkg::bma_mode_indirect;
  localparam logic [2:0] m_pi = bma_pkg::bma_mode_post_inc;
  localparam logic [2:0] m_pd = bma_pkg::bma_mode_post_dec;
  localparam logic [2:0] m_ri = bma_pkg::bma_mode_pre_inc;
  localparam logic [2:0] m_rd = bma_pkg::bma_mode_pre_dec;
  localparam logic [2:0] m_ro = bma_pkg::bma_mode_reg_offset;
  logic        clock_in = 1'h0;
  logic        rst_in   = 1'h1;
  logic        req      = 1'h0;
  logic        ld       = 1'h0;
  logic        men      = 1'h1;
  logic [3:0]  msel     = 4'h2;
  logic [15:0] mst      = 16'h0800;
  logic [15:0] mend     = 16'h080F;
  logic [3:0]  bsel     = 4'h3;
  logic        ben      = 1'h1;
  logic [14:0] bmod     = 15'h0008;
  logic        hz_exp   = 1'h0;
  logic        ea_val, wb_en, br_act, wrapped, hazard;
  logic [15:0] ea, wb_val, ptr_val;
  logic [3:0]  wb_idx;
  int          n_mismatch = 0;
  int          num_checks = 0;
  bma_row_s    cur = '0;
  // Reversal buffer sits at 0x1000, aligned to its size
  bma_row_s    rows [16] = '{
    '{4'h3, 16'h1000, 16'h0000, m_pi, 1'h0, 1'h1, 16'h1000, 1'h1, 16'h1010, 1'h1, 1'h0},
    '{4'h3, 16'h1011, 16'h0000, m_pi, 1'h0, 1'h1, 16'h1010, 1'h1, 16'h1008, 1'h1, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, m_ri, 1'h0, 1'h1, 16'h1010, 1'h1, 16'h1010, 1'h1, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, m_pi, 1'h1, 1'h1, 16'h1000, 1'h1, 16'h1001, 1'h0, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, m_pi, 1'h0, 1'h0, 16'h1000, 1'h1, 16'h1002, 1'h0, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, m_pd, 1'h0, 1'h1, 16'h1000, 1'h1, 16'h0FFE, 1'h0, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, m_in, 1'h0, 1'h1, 16'h1000, 1'h0, 16'h0000, 1'h0, 1'h0},
    '{4'h2, 16'h080E, 16'h0000, m_ri, 1'h0, 1'h1, 16'h0800, 1'h1, 16'h0800, 1'h0, 1'h1},
    '{4'h2, 16'h080E, 16'h0000, m_pi, 1'h0, 1'h1, 16'h080E, 1'h1, 16'h0800, 1'h0, 1'h1},
    '{4'h2, 16'h0800, 16'h0000, m_pd, 1'h0, 1'h0, 16'h0800, 1'h1, 16'h080E, 1'h0, 1'h1},
    '{4'h2, 16'h0800, 16'h0000, m_rd, 1'h1, 1'h0, 16'h080F, 1'h1, 16'h080F, 1'h0, 1'h1},
    '{4'h2, 16'h080C, 16'h0006, m_ro, 1'h0, 1'h0, 16'h0802, 1'h0, 16'h0000, 1'h0, 1'h1},
    '{4'h2, 16'h080C, 16'h000A, m_ro, 1'h0, 1'h1, 16'h0806, 1'h0, 16'h0000, 1'h0, 1'h1},
    '{4'h2, 16'h0802, 16'hFFFA, m_ro, 1'h0, 1'h0, 16'h080C, 1'h0, 16'h0000, 1'h0, 1'h1},
    '{4'h4, 16'h080E, 16'h0000, m_pi, 1'h0, 1'h0, 16'h080E, 1'h1, 16'h0810, 1'h0, 1'h0},
    '{4'h3, 16'h1000, 16'h0000, 3'h6, 1'h0, 1'h1, 16'h1000, 1'h0, 16'h0000, 1'h0, 1'h0}};

  always #2 clock_in = ~clock_in;

  bma_core_model u_bma_core_model (
    .clock_in(clock_in), .rst_in(rst_in), .load_in(ld), .index_in(cur.idx),
    .load_value_in(cur.ptr), .wb_en_in(wb_en), .wb_index_in(wb_idx),
    .wb_value_in(wb_val), .ptr_value_out(ptr_val));

  bma_address_gen u_bma_address_gen (
    .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req), .ptr_index_in(cur.idx),
    .ptr_value_in(ptr_val), .offset_value_in(cur.off), .mode_in(cur.mode),
    .size_byte_in(cur.byt), .write_in(cur.wr), .modulo_enable_in(men),
    .modulo_pointer_select_in(msel), .modulo_start_in(mst), .modulo_end_in(mend),
    .base_pointer_select_in(bsel), .bitrev_enable_in(ben),
    .bitrev_modifier_value_in(bmod), .ea_valid_out(ea_val), .ea_out(ea),
    .wb_en_out(wb_en), .wb_index_out(wb_idx), .wb_value_out(wb_val),
    .bitrev_active_out(br_act), .modulo_wrapped_out(wrapped),
    .modifier_hazard_out(hazard));

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask

  // Outputs are sampled half a cycle after the taking edge
  task automatic chk_row(input bma_row_s r);
    chk1("ea_valid", 1'h1, ea_val);
    chk16("ea", r.ea, ea);
    chk1("wb_en", r.wben, wb_en);
    if (r.wben)
    begin
      chk16("wb_value", r.wbv, wb_val);
      chk16("wb_index", {12'h000, r.idx}, {12'h000, wb_idx});
    end
    chk1("bitrev", r.br, br_act);
    chk1("wrapped", r.wrp, wrapped);
    chk1("hazard", hz_exp, hazard);
  endtask

  // Preload the pointer, then one request; the spare cycle lets write-back land
  task automatic do_req(input bma_row_s r, input logic hzd);
    @(negedge clock_in);
    cur = r;
    ld = 1'h1;
    @(negedge clock_in);
    ld = 1'h0;
    if (hzd)
    begin
      bmod = 15'h0010;
      @(negedge clock_in);
    end
    req = 1'h1;
    @(negedge clock_in);
    req = 1'h0;
    hz_exp = hzd;
    chk_row(r);
    hz_exp = 1'h0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(negedge clock_in);
    chk1("reset ea_valid", 1'h0, ea_val);
    chk16("reset ea", 16'h0000, ea);
    rst_in = 1'h0;
    foreach (rows[i])
      do_req(rows[i], 1'h0);
    // Same pointer for modulo and reversal: reversal must win
    msel = 4'h3;
    mst = 16'h1000;
    mend = 16'h100F;
    // Modulo alone would wrap this pointer back to the buffer start
    do_req('{4'h3, 16'h100E, 16'h0000, m_pi, 1'h0, 1'h1,
             16'h100E, 1'h1, 16'h101E, 1'h1, 1'h0}, 1'h0);
    bsel = 4'hF;
    do_req('{4'hF, 16'h1000, 16'h0000, m_pi, 1'h0, 1'h1,
             16'h1000, 1'h1, 16'h1002, 1'h0, 1'h0}, 1'h0);
    bsel = 4'h3;
    ben = 1'h0;
    do_req('{4'h3, 16'h1000, 16'h0000, m_pi, 1'h0, 1'h1,
             16'h1000, 1'h1, 16'h1002, 1'h0, 1'h0}, 1'h0);
    // Back to the first modulo buffer; later offset cases rely on it
    ben = 1'h1;
    msel = 4'h2;
    mst = 16'h0800;
    mend = 16'h080F;
    bmod = 15'h4000;
    do_req('{4'h3, 16'h0000, 16'h0000, m_pi, 1'h0, 1'h1,
             16'h0000, 1'h1, 16'h8000, 1'h1, 1'h0}, 1'h0);
    // Modifier rewritten right before a read through the reversal pointer
    do_req('{4'h3, 16'h1000, 16'h0000, m_pi, 1'h0, 1'h0,
             16'h1000, 1'h1, 16'h1002, 1'h0, 1'h0}, 1'h1);
    // Back-to-back requests with the strobe held high
    @(negedge clock_in);
    cur = '{4'h2, 16'h080C, 16'h0006, m_ro, 1'h0, 1'h0, 16'h0802, 1'h0, 16'h0000, 1'h0, 1'h1};
    ld = 1'h1;
    @(negedge clock_in);
    ld = 1'h0;
    req = 1'h1;
    @(negedge clock_in);
    chk_row(cur);
    cur = '{4'h2, 16'h080C, 16'h0000, m_ri, 1'h0, 1'h0, 16'h080E, 1'h1, 16'h080E, 1'h0, 1'h0};
    @(negedge clock_in);
    req = 1'h0;
    chk_row(cur);
    // Second reset in mid-run clears the results
    rst_in = 1'h1;
    @(negedge clock_in);
    chk16("reset ea", 16'h0000, ea);
    chk1("reset wb_en", 1'h0, wb_en);
    rst_in = 1'h0;
    // No request yet, so no valid pulse after release
    @(negedge clock_in);
    chk1("idle ea_valid", 1'h0, ea_val);
    do_req(rows[7], 1'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire
